// >>> rtl/tide_regs.svh
// Purpose: Shared constants for the parallel storage port, both ends
// Assumes: 125 MHz reference clock, all times in ns
// Notes: Mode tables are indexed by the transfer mode number
// Functional notes
// - Host meets PIO cycle, active and recovery together
// - Host holds PIO strobe mode minimum, 8-bit longer in modes 0-2
// - Host keeps PIO strobes inactive recovery minimum
// - Host samples ready at 35 ns, then waits
// - Device drives read data before raising ready
// - Device holds ready low at most 1250 ns
// - Wait only when ready low at sample
// - 16-bit indication valid only PIO modes 0-2
// - Two selects plus 3-bit address, 16/8-bit data
// - Host meets DMA cycle, active and recovery together
// - Host holds DMA strobe mode minimum width
// - Host keeps DMA strobes negated mode minimum
// - Acknowledge before first strobe, held after last
// - Device drops DMA request soon after strobe
// - Device may suspend burst by dropping request
// - Host may suspend burst by dropping acknowledge
`ifndef TIDE_REGS_SVH
`define TIDE_REGS_SVH

`define TIDE_CLK_NS 8
`define TIDE_CYC_MIN(ns) (((ns) + `TIDE_CLK_NS - 1) / `TIDE_CLK_NS)
`define TIDE_CYC_MAX(ns) ((ns) / `TIDE_CLK_NS)

`define TIDE_PIO_T0_NS '{600, 383, 240, 180, 120, 100, 80}
`define TIDE_PIO_T1_NS '{70, 50, 30, 30, 10, 10, 10}
`define TIDE_PIO_T2_NS '{165, 125, 100, 80, 55, 55, 55}
`define TIDE_PIO_T2I_NS '{0, 0, 0, 70, 20, 20, 20}
`define TIDE_PIO_T2_REG8_NS 290
`define TIDE_PIO_TA_NS 35
`define TIDE_PIO_TB_NS 1250
`define TIDE_PIO_MAX 3'h6
`define TIDE_PIO_CS16_MAX 3'h2

`define TIDE_DMA_TO_NS '{480, 150, 120, 100, 80}
`define TIDE_DMA_TD_NS '{215, 80, 70, 60, 55}
`define TIDE_DMA_TKR_NS '{50, 50, 25, 20, 20}
`define TIDE_DMA_TKW_NS '{215, 50, 25, 20, 20}
`define TIDE_DMA_TJ_NS '{20, 5, 5, 5, 5}
`define TIDE_DMA_MAX 3'h4

`define TIDE_REG_DATA 3'h0
`define TIDE_BUS_IDLE 16'hffff
`define TIDE_BYTE_ZERO 8'h00
`define TIDE_CNT_ONE 8'h01
`define TIDE_CNT_SAT 8'hff

`endif

// >>> rtl/tide_pkg.sv
// Purpose: Types for the parallel storage port
// Assumes: Constants come from tide_regs.svh
// Notes: None
package tide_pkg;
    typedef logic [2:0] tide_mode_t;
    typedef logic [7:0] tide_cnt_t;
    typedef enum {HS_IDLE, HS_SETUP, HS_ACTIVE, HS_RECOV} tide_hstate_t;
endpackage

// >>> rtl/tide_if.sv
// Purpose: Pin bundle between host controller and storage device
// Assumes: Output enables are active low
// Notes: Resolves the shared data bus and the 16-bit indication
`timescale 1ns/1ps
`include "tide_regs.svh"
interface tide_if;
    logic cs0_n;
    logic cs1_n;
    logic [2:0] addr;
    logic iord_n;
    logic iowr_n;
    logic dmack_n;
    logic [15:0] hdata;
    logic hdata_oe_n;
    logic [15:0] ddata;
    logic ddata_oe_n;
    logic iordy;
    logic iocs16_drv_n;
    logic iocs16_oe_n;
    logic dmarq;
    logic [15:0] data;
    logic iocs16_n;

    // Undriven lines float high
    assign data = !hdata_oe_n ? hdata : (!ddata_oe_n ? ddata : `TIDE_BUS_IDLE);
    assign iocs16_n = iocs16_oe_n ? 1'b1 : iocs16_drv_n;

    modport host (
        output cs0_n, cs1_n, addr, iord_n, iowr_n, dmack_n, hdata, hdata_oe_n,
        input data, iordy, iocs16_n, dmarq
    );
    modport dev (
        input cs0_n, cs1_n, addr, iord_n, iowr_n, dmack_n, data,
        output ddata, ddata_oe_n, iordy, iocs16_drv_n, iocs16_oe_n, dmarq
    );
endinterface

// >>> rtl/tide_dev.sv
// Purpose: Storage device end of the parallel port
// Assumes: Pins synchronous to ref_clk_i
// Notes: Data register at select 0, address 0; others are 8-bit
`timescale 1ns/1ps
`include "tide_regs.svh"
module tide_dev
    import tide_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    tide_if.dev bus,
    input wire tide_mode_t pio_mode_i,
    input wire logic dma_en_i,
    input wire logic dma_to_host_i,
    input wire logic tx_valid_i,
    input wire logic [15:0] tx_data_i,
    output logic tx_ready_o,
    output logic rx_valid_o,
    output logic [15:0] rx_data_o,
    input wire logic rx_ready_i,
    output logic wait_timeout_o
);
    localparam tide_cnt_t TB_C = tide_cnt_t'(`TIDE_CYC_MAX(`TIDE_PIO_TB_NS));

    function automatic logic is_data(input logic c0_n, input logic c1_n,
                                     input logic [2:0] a);
        return !c0_n && c1_n && (a == `TIDE_REG_DATA);
    endfunction

    logic [7:0] regs [16];
    logic prev_rd;
    logic prev_wr;
    logic pend_rd;
    logic pend_wr;
    tide_cnt_t wcnt;
    logic [15:0] dout;
    logic dma_sel;
    logic hit;
    logic port;
    logic rd_fall;
    logic wr_fall;
    logic wr_rise;
    logic timeout;
    logic dma_strobe;
    logic [3:0] idx;

    // ****************************************
    // Address decode
    // ****************************************
    assign dma_sel = !bus.dmack_n;
    assign hit = (bus.cs0_n ^ bus.cs1_n) || dma_sel;
    assign port = dma_sel || is_data(bus.cs0_n, bus.cs1_n, bus.addr);
    assign idx = {!bus.cs1_n, bus.addr};
    assign rd_fall = prev_rd && !bus.iord_n;
    assign wr_fall = prev_wr && !bus.iowr_n;
    assign wr_rise = !prev_wr && bus.iowr_n;
    assign timeout = (pend_rd || pend_wr) && (wcnt == TB_C - `TIDE_CNT_ONE);

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            prev_rd <= 1'b1;
            prev_wr <= 1'b1;
        end else begin
            prev_rd <= bus.iord_n;
            prev_wr <= bus.iowr_n;
        end
    end

    // ****************************************
    // Read path and ready extension
    // ****************************************
    assign tx_ready_o = hit && port && !bus.iord_n && tx_valid_i && (rd_fall || pend_rd);

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            pend_rd <= 1'b0;
            dout <= 16'h0000;
        end else begin
            if (tx_ready_o) begin
                dout <= tx_data_i;
                pend_rd <= 1'b0;
            end else if (rd_fall && hit && port) begin
                pend_rd <= !dma_sel;
            end else if (rd_fall && hit) begin
                dout <= {`TIDE_BYTE_ZERO, regs[idx]};
            end
            if (timeout) begin
                pend_rd <= 1'b0;
            end
        end
    end

    // Ready lags the pending flag, so data leads it by a cycle
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            bus.iordy <= 1'b1;
            wcnt <= '0;
            wait_timeout_o <= 1'b0;
        end else begin
            bus.iordy <= !(pend_rd || pend_wr);
            wait_timeout_o <= timeout;
            if (pend_rd || pend_wr) begin
                wcnt <= wcnt + `TIDE_CNT_ONE;
            end else begin
                wcnt <= '0;
            end
        end
    end

    assign bus.ddata = dout;
    assign bus.ddata_oe_n = !(!bus.iord_n && hit);

    // Indication driven only in the slow modes
    assign bus.iocs16_drv_n = 1'b0;
    assign bus.iocs16_oe_n = !(is_data(bus.cs0_n, bus.cs1_n, bus.addr)
                               && (pio_mode_i <= `TIDE_PIO_CS16_MAX));

    // ****************************************
    // Write path
    // ****************************************
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            rx_valid_o <= 1'b0;
            rx_data_o <= 16'h0000;
            pend_wr <= 1'b0;
            for (int i = 0; i < 16; i++) begin
                regs[i] <= `TIDE_BYTE_ZERO;
            end
        end else begin
            if (rx_valid_o && rx_ready_i) begin
                rx_valid_o <= 1'b0;
            end
            if (wr_rise && hit && port) begin
                rx_valid_o <= 1'b1;
                rx_data_o <= bus.data;
            end else if (wr_rise && hit) begin
                regs[idx] <= bus.data[7:0];
            end
            if (wr_fall && hit && port && !dma_sel && rx_valid_o && !rx_ready_i) begin
                pend_wr <= 1'b1;
            end else if (!rx_valid_o || rx_ready_i || timeout) begin
                pend_wr <= 1'b0;
            end
        end
    end

    // ****************************************
    // DMA request
    // ****************************************
    // Acknowledge may vanish at any strobe gap; nothing is held on it
    assign dma_strobe = dma_sel && (!bus.iord_n || !bus.iowr_n || wr_rise);

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            bus.dmarq <= 1'b0;
        end else begin
            bus.dmarq <= dma_en_i && !dma_strobe
                && (dma_to_host_i ? (tx_valid_i && !tx_ready_o) : !rx_valid_o);
        end
    end
endmodule

// >>> rtl/tide_host.sv
// Purpose: Host controller end of the parallel port
// Assumes: Pins synchronous to ref_clk_i; modes stable per request
// Notes: Read words pass a small buffer before the user side
`timescale 1ns/1ps
`include "tide_regs.svh"
module tide_host
    import tide_pkg::*;
#(
    parameter int DEPTH = 2
) (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    tide_if.host bus,
    input wire tide_mode_t pio_mode_i,
    input wire tide_mode_t mdma_mode_i,
    input wire logic req_valid_i,
    output logic req_ready_o,
    input wire logic req_write_i,
    input wire logic req_dma_i,
    input wire logic req_reg8_i,
    input wire logic req_cs1_i,
    input wire logic [2:0] req_addr_i,
    input wire logic [15:0] req_wdata_i,
    output logic rsp_valid_o,
    input wire logic rsp_ready_i,
    output logic [15:0] rsp_data_o,
    output logic cs16_o,
    output logic busy_o
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam int PIO_T0[7] = `TIDE_PIO_T0_NS;
    localparam int PIO_T1[7] = `TIDE_PIO_T1_NS;
    localparam int PIO_T2[7] = `TIDE_PIO_T2_NS;
    localparam int PIO_T2I[7] = `TIDE_PIO_T2I_NS;
    localparam int DMA_TO[5] = `TIDE_DMA_TO_NS;
    localparam int DMA_TD[5] = `TIDE_DMA_TD_NS;
    localparam int DMA_TKR[5] = `TIDE_DMA_TKR_NS;
    localparam int DMA_TKW[5] = `TIDE_DMA_TKW_NS;
    localparam int DMA_TJ[5] = `TIDE_DMA_TJ_NS;
    localparam tide_cnt_t TA_C = tide_cnt_t'(`TIDE_CYC_MIN(`TIDE_PIO_TA_NS));

    function automatic tide_cnt_t cyc_min(input int ns);
        int c;
        c = `TIDE_CYC_MIN(ns);
        if (c < 1) begin
            c = 1;
        end
        return c[7:0];
    endfunction

    function automatic int max_of(input int a, input int b);
        return (a > b) ? a : b;
    endfunction

    tide_hstate_t state;
    tide_cnt_t cnt;
    logic waiting;
    logic op_wr;
    logic op_dma;
    logic op_reg8;
    logic op_cs1;
    logic [2:0] op_addr;
    logic [15:0] op_wdata;
    tide_mode_t op_pm;
    tide_mode_t op_dm;
    int t_pm;
    int t_dm;
    int t_act;
    int t_rcv;
    int t_cyc;
    int t_hold;
    tide_cnt_t set_c;
    tide_cnt_t act_c;
    tide_cnt_t rec_c;
    logic room;
    logic can_take;
    logic accept;
    logic cont;
    logic stall;
    logic end_now;
    logic rec_done;
    logic push;
    logic pop;
    logic [15:0] mem [DEPTH];
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [CW-1:0] f_cnt;

    // ****************************************
    // Mode parameter selection
    // ****************************************
    always_comb begin
        t_pm = int'((op_pm > `TIDE_PIO_MAX) ? `TIDE_PIO_MAX : op_pm);
        t_dm = int'((op_dm > `TIDE_DMA_MAX) ? `TIDE_DMA_MAX : op_dm);
        if (op_dma) begin
            t_act = DMA_TD[t_dm];
            t_rcv = op_wr ? DMA_TKW[t_dm] : DMA_TKR[t_dm];
            t_cyc = DMA_TO[t_dm];
            t_hold = DMA_TJ[t_dm];
            set_c = cyc_min(0);
        end else begin
            if (op_reg8 && (op_pm <= `TIDE_PIO_CS16_MAX)) begin
                t_act = `TIDE_PIO_T2_REG8_NS;
            end else begin
                t_act = PIO_T2[t_pm];
            end
            t_rcv = PIO_T2I[t_pm];
            t_cyc = PIO_T0[t_pm];
            t_hold = 0;
            set_c = cyc_min(PIO_T1[t_pm]);
        end
        act_c = cyc_min(t_act);
        // Recovery stretched so that active plus inactive reaches the cycle
        rec_c = cyc_min(max_of(max_of(t_rcv, t_cyc - t_act), t_hold));
    end

    // ****************************************
    // Request acceptance
    // ****************************************
    assign room = f_cnt < CW'(DEPTH);
    assign can_take = req_valid_i && (!req_dma_i || bus.dmarq) && (req_write_i || room);
    assign accept = (state == HS_IDLE) && can_take;
    assign cont = op_dma && can_take && req_dma_i && (req_write_i == op_wr);
    assign rec_done = (state == HS_RECOV) && (cnt + `TIDE_CNT_ONE >= rec_c);
    assign req_ready_o = accept || (rec_done && cont);

    // Ready low at the sample point, or still low while waiting
    assign stall = !op_dma && !bus.iordy && (waiting || (cnt == TA_C));
    assign end_now = (state == HS_ACTIVE) && (cnt + `TIDE_CNT_ONE >= act_c) && !stall;

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            op_wr <= 1'b0;
            op_dma <= 1'b0;
            op_reg8 <= 1'b0;
            op_cs1 <= 1'b0;
            op_addr <= 3'h0;
            op_wdata <= 16'h0000;
            op_pm <= 3'h0;
            op_dm <= 3'h0;
        end else if (accept) begin
            op_wr <= req_write_i;
            op_dma <= req_dma_i;
            op_reg8 <= req_reg8_i;
            op_cs1 <= req_cs1_i;
            op_addr <= req_addr_i;
            op_wdata <= req_wdata_i;
            op_pm <= pio_mode_i;
            op_dm <= mdma_mode_i;
        end else if (rec_done && cont) begin
            op_wdata <= req_wdata_i;
        end
    end

    // ****************************************
    // Cycle sequencer
    // ****************************************
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            state <= HS_IDLE;
            cnt <= '0;
        end else begin
            case (state)
                HS_IDLE: begin
                    cnt <= '0;
                    if (accept) begin
                        state <= HS_SETUP;
                    end
                end
                HS_SETUP: begin
                    if (cnt + `TIDE_CNT_ONE >= set_c) begin
                        state <= HS_ACTIVE;
                        cnt <= '0;
                    end else begin
                        cnt <= cnt + `TIDE_CNT_ONE;
                    end
                end
                HS_ACTIVE: begin
                    if (end_now) begin
                        state <= HS_RECOV;
                        cnt <= '0;
                    end else if (cnt != `TIDE_CNT_SAT) begin
                        cnt <= cnt + `TIDE_CNT_ONE;
                    end
                end
                HS_RECOV: begin
                    if (rec_done) begin
                        state <= cont ? HS_ACTIVE : HS_IDLE;
                        cnt <= '0;
                    end else begin
                        cnt <= cnt + `TIDE_CNT_ONE;
                    end
                end
                default: begin
                    state <= HS_IDLE;
                    cnt <= '0;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i || (state != HS_ACTIVE)) begin
            waiting <= 1'b0;
        end else if ((cnt == TA_C) && !bus.iordy && !op_dma) begin
            waiting <= 1'b1;
        end else if (bus.iordy) begin
            waiting <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            cs16_o <= 1'b0;
        end else if (end_now && !op_dma) begin
            cs16_o <= (op_pm <= `TIDE_PIO_CS16_MAX) && !bus.iocs16_n;
        end
    end

    // ****************************************
    // Pins
    // ****************************************
    assign busy_o = state != HS_IDLE;
    assign bus.cs0_n = !(busy_o && !op_dma && !op_cs1);
    assign bus.cs1_n = !(busy_o && !op_dma && op_cs1);
    assign bus.addr = op_addr;
    assign bus.iord_n = !((state == HS_ACTIVE) && !op_wr);
    assign bus.iowr_n = !((state == HS_ACTIVE) && op_wr);
    // Acknowledge spans setup through the last recovery
    assign bus.dmack_n = !(busy_o && op_dma);
    assign bus.hdata = op_wdata;
    assign bus.hdata_oe_n = !(busy_o && op_wr);

    // ****************************************
    // Read buffer
    // ****************************************
    assign push = end_now && !op_wr;
    assign pop = rsp_valid_o && rsp_ready_i;
    assign rsp_valid_o = f_cnt != '0;
    assign rsp_data_o = mem[rp];

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            wp <= '0;
            rp <= '0;
            f_cnt <= '0;
        end else begin
            if (push) begin
                mem[wp] <= bus.data;
                wp <= (wp == PW'(DEPTH - 1)) ? '0 : wp + 1'b1;
            end
            if (pop) begin
                rp <= (rp == PW'(DEPTH - 1)) ? '0 : rp + 1'b1;
            end
            if (push && !pop) begin
                f_cnt <= f_cnt + 1'b1;
            end else if (pop && !push) begin
                f_cnt <= f_cnt - 1'b1;
            end
        end
    end
endmodule

// >>> testbench/tide_monitor.sv
// Purpose: Concurrent checks on the pins between host and device ends
// Assumes: Both ends run on ref_clk_i at 125 MHz
// Notes: Widths use the fastest mode figures
`timescale 1ns/1ps
module tide_monitor (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic cs0_n,
    input wire logic cs1_n,
    input wire logic iord_n,
    input wire logic iowr_n,
    input wire logic dmack_n,
    input wire logic [15:0] data,
    input wire logic hdata_oe_n,
    input wire logic ddata_oe_n,
    input wire logic iordy,
    input wire logic dmarq
);
    localparam int READY_MAX = 156;
    logic [7:0] low_cnt;

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    // Cycles in a row with ready low
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i || iordy) begin
            low_cnt <= 8'h00;
        end else if (low_cnt != 8'hff) begin
            low_cnt <= low_cnt + 8'h01;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    rd_width_a: assert property ($fell(iord_n) |-> !iord_n [*7])
        else $error("read strobe too short");
    wr_width_a: assert property ($fell(iowr_n) |-> !iowr_n [*7])
        else $error("write strobe too short");
    strobe_gap_a: assert property ($rose(iord_n) || $rose(iowr_n) |-> (iord_n && iowr_n) [*3])
        else $error("strobe recovery too short");
    ready_max_a: assert property (low_cnt <= READY_MAX)
        else $error("ready held low too long");
    read_lead_a: assert property ($rose(iordy) && !iord_n |-> !ddata_oe_n && $stable(data))
        else $error("read data not ahead of ready");
    wait_end_a: assert property ($rose(iord_n) || $rose(iowr_n) |-> $past(iordy))
        else $error("strobe ended while ready low");
    bus_turn_a: assert property (!ddata_oe_n |-> hdata_oe_n && (!iord_n || !$past(iord_n)))
        else $error("device drives bus outside a read");
    ack_setup_a: assert property (!dmack_n && ($fell(iord_n) || $fell(iowr_n)) |-> !$past(dmack_n))
        else $error("acknowledge not ahead of strobe");
    ack_hold_a: assert property ($rose(dmack_n)
        |-> $past(iord_n) && $past(iowr_n))
        else $error("acknowledge dropped during strobe");
    req_drop_a: assert property (!dmack_n && ($fell(iord_n) || $fell(iowr_n)) |-> ##[1:4] !dmarq)
        else $error("request not dropped after strobe");
    sel_strobe_a: assert property (!iord_n || !iowr_n |-> (cs0_n ^ cs1_n) || !dmack_n)
        else $error("strobe without select");

    cover property ($rose(iordy) && !iord_n);
    cover property (!dmack_n && $fell(iowr_n));
    cover property (!dmack_n && $fell(iord_n));
    cover property (low_cnt == 8'h96);
endmodule

// >>> testbench/testbench.sv
// Purpose: Drives host and device user sides across the pin bundle
// Assumes: 125 MHz clock, synchronous active low reset
// Notes: Runs every PIO and DMA mode, waits, stalls and refusals
`timescale 1ns/1ps
`include "tide_regs.svh"
module testbench
    import tide_pkg::*;
;
    logic ref_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    tide_mode_t pmode = 3'h0;
    tide_mode_t dmode = 3'h0;
    logic reqv = 1'b0, reqw = 1'b0, reqd = 1'b0, req8 = 1'b0, reqc = 1'b0;
    logic [2:0] reqa = 3'h0;
    logic [15:0] reqwd = 16'h0000, txd = 16'h0000;
    logic rspr = 1'b0, dmaen = 1'b0, dmadir = 1'b0, txv = 1'b0, rxr = 1'b0;
    logic req_ready, rspv, cs16, busy, txr, rxv, wto, rdy_low, cs16_low;
    logic [15:0] rspd, rxd;
    int err_total = 0;
    int samples_checked = 0;
    int act_len, n_pop;
    localparam int T2[7] = `TIDE_PIO_T2_NS;

    tide_if bus_if ();
    tide_host #(.DEPTH(2)) i_tide_host (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
        .bus(bus_if.host), .pio_mode_i(pmode), .mdma_mode_i(dmode), .req_valid_i(reqv),
        .req_ready_o(req_ready), .req_write_i(reqw), .req_dma_i(reqd), .req_reg8_i(req8),
        .req_cs1_i(reqc), .req_addr_i(reqa), .req_wdata_i(reqwd), .rsp_valid_o(rspv),
        .rsp_ready_i(rspr), .rsp_data_o(rspd), .cs16_o(cs16), .busy_o(busy));
    tide_dev i_tide_dev (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .bus(bus_if.dev),
        .pio_mode_i(pmode), .dma_en_i(dmaen), .dma_to_host_i(dmadir), .tx_valid_i(txv),
        .tx_data_i(txd), .tx_ready_o(txr), .rx_valid_o(rxv), .rx_data_o(rxd),
        .rx_ready_i(rxr), .wait_timeout_o(wto));
    tide_monitor i_tide_monitor (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
        .cs0_n(bus_if.cs0_n), .cs1_n(bus_if.cs1_n), .iord_n(bus_if.iord_n),
        .iowr_n(bus_if.iowr_n), .dmack_n(bus_if.dmack_n), .data(bus_if.data),
        .hdata_oe_n(bus_if.hdata_oe_n), .ddata_oe_n(bus_if.ddata_oe_n),
        .iordy(bus_if.iordy), .dmarq(bus_if.dmarq));

    always #4 ref_clk_i = ~ref_clk_i;

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic end_sim();
        if (err_total == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic give_up();
        err_total++;
        end_sim();
    endtask

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic send(input logic w, d, r8, input logic [3:0] ca, input logic [15:0] wd);
        @(posedge ref_clk_i);
        reqv <= 1'b1;
        {reqw, reqd, req8, reqc, reqa, reqwd} <= {w, d, r8, ca, wd};
        @(negedge ref_clk_i);
        for (int n = 0; n < 400 && req_ready !== 1'b1; n++) @(negedge ref_clk_i);
        if (req_ready !== 1'b1) give_up();
        @(posedge ref_clk_i);
        reqv <= 1'b0;
    endtask

    task automatic refuse(input logic w, d, input logic [2:0] a);
        logic hit;
        hit = 1'b0;
        @(posedge ref_clk_i);
        reqv <= 1'b1;
        {reqw, reqd, req8, reqc, reqa} <= {w, d, 1'b1, 1'b0, a};
        repeat (30) begin
            @(negedge ref_clk_i);
            hit |= req_ready;
        end
        @(posedge ref_clk_i);
        reqv <= 1'b0;
        check("refused request", {15'h0000, hit}, 16'h0000);
    endtask

    task automatic take(output logic [15:0] v);
        @(negedge ref_clk_i);
        for (int n = 0; n < 400 && rspv !== 1'b1; n++) @(negedge ref_clk_i);
        if (rspv !== 1'b1) give_up();
        v = rspd;
        @(posedge ref_clk_i);
        rspr <= 1'b1;
        @(posedge ref_clk_i);
        rspr <= 1'b0;
    endtask

    task automatic take_rx(output logic [15:0] v);
        @(negedge ref_clk_i);
        for (int n = 0; n < 400 && rxv !== 1'b1; n++) @(negedge ref_clk_i);
        if (rxv !== 1'b1) give_up();
        v = rxd;
        @(posedge ref_clk_i);
        rxr <= 1'b1;
        @(posedge ref_clk_i);
        rxr <= 1'b0;
    endtask

    task automatic idle();
        @(negedge ref_clk_i);
        for (int n = 0; n < 400 && busy !== 1'b0; n++) begin
            rdy_low |= !bus_if.iordy;
            cs16_low |= !bus_if.iocs16_n;
            act_len += !bus_if.iord_n;
            n_pop += txr;
            @(negedge ref_clk_i);
        end
        if (busy !== 1'b0) give_up();
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic s_regs();
        logic [15:0] v;
        for (int k = 1; k < 16; k++) send(1'b1, 1'b0, 1'b1, k[3:0], {8'ha5, 4'h3, k[3:0]});
        for (int k = 1; k < 16; k++) begin
            send(1'b0, 1'b0, 1'b1, k[3:0], 16'h0000);
            take(v);
            check("scratch read", v, {8'h00, 4'h3, k[3:0]});
        end
    endtask

    task automatic s_buffer();
        logic [15:0] v;
        send(1'b0, 1'b0, 1'b1, 4'h1, 16'h0000);
        send(1'b0, 1'b0, 1'b1, 4'h2, 16'h0000);
        idle();
        refuse(1'b0, 1'b0, 3'h3);
        take(v);
        check("first buffered", v, 16'h0031);
        take(v);
        check("second buffered", v, 16'h0032);
    endtask

    task automatic s_pio();
        logic [15:0] v;
        for (int m = 0; m < 7; m++) begin
            @(posedge ref_clk_i);
            pmode <= 3'(m);
            txv <= 1'b1;
            txd <= 16'h3c00 | 16'(m);
            send(1'b1, 1'b0, 1'b0, 4'h0, 16'hc300 | 16'(m));
            take_rx(v);
            check("written word", v, 16'hc300 | 16'(m));
            {rdy_low, cs16_low} = 2'b00;
            act_len = 0;
            n_pop = 0;
            send(1'b0, 1'b0, 1'b0, 4'h0, 16'h0000);
            idle();
            check("no wait", {15'h0000, rdy_low}, 16'h0000);
            check("width line", {15'h0000, cs16_low}, {15'h0000, m < 3});
            check("width out", {15'h0000, cs16}, {15'h0000, m < 3});
            check("strobe length", 16'(act_len), 16'(`TIDE_CYC_MIN(T2[m])));
            check("word taken", 16'(n_pop), 16'h0001);
            take(v);
            check("read word", v, 16'h3c00 | 16'(m));
        end
        @(posedge ref_clk_i);
        txv <= 1'b0;
    endtask

    task automatic s_wait();
        logic [15:0] v;
        int at;
        @(posedge ref_clk_i);
        pmode <= 3'h4;
        send(1'b0, 1'b0, 1'b0, 4'h0, 16'h0000);
        repeat (20) @(negedge ref_clk_i);
        check("held strobe", {14'h0000, bus_if.iord_n, bus_if.iordy}, 16'h0000);
        @(posedge ref_clk_i);
        txv <= 1'b1;
        txd <= 16'h9e17;
        take(v);
        check("late word", v, 16'h9e17);
        @(posedge ref_clk_i);
        txv <= 1'b0;
        at = 0;
        send(1'b0, 1'b0, 1'b0, 4'h0, 16'h0000);
        for (int n = 1; n < 200 && at == 0; n++) begin
            @(negedge ref_clk_i);
            if (wto === 1'b1) at = n;
        end
        check("forced end", {15'h0000, at > 140 && at < 165}, 16'h0001);
        take(v);
    endtask

    task automatic s_stall();
        logic [15:0] v;
        send(1'b1, 1'b0, 1'b0, 4'h0, 16'h1234);
        send(1'b1, 1'b0, 1'b0, 4'h0, 16'h5678);
        repeat (30) @(negedge ref_clk_i);
        check("stalled write", {14'h0000, busy, bus_if.iordy}, 16'h0002);
        take_rx(v);
        check("first word", v, 16'h1234);
        take_rx(v);
        check("second word", v, 16'h5678);
    endtask

    task automatic s_dma();
        logic [15:0] v;
        @(posedge ref_clk_i);
        dmaen <= 1'b1;
        for (int m = 0; m < 5; m++) begin
            @(posedge ref_clk_i);
            dmode <= 3'(m);
            dmadir <= 1'b0;
            send(1'b1, 1'b1, 1'b0, 4'h0, 16'hd000 | 16'(m));
            take_rx(v);
            check("dma in", v, 16'hd000 | 16'(m));
            @(posedge ref_clk_i);
            dmadir <= 1'b1;
            txv <= 1'b1;
            txd <= 16'he000 | 16'(m);
            send(1'b0, 1'b1, 1'b0, 4'h0, 16'h0000);
            take(v);
            check("dma out", v, 16'he000 | 16'(m));
            @(posedge ref_clk_i);
            txv <= 1'b0;
        end
        dmaen <= 1'b0;
        refuse(1'b1, 1'b1, 3'h0);
    endtask

    initial begin
        repeat (16) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        s_regs();
        s_buffer();
        s_pio();
        s_wait();
        s_stall();
        s_dma();
        end_sim();
    end
endmodule
